/* File: wake_pattern_detector.sv */
`timescale 1ns/100ps
`default_nettype none


// ****************************************
// Wake pattern detector top
// ****************************************
// Avalon-MM registers, mode and
// notify logic, one byte scanner
// Map: 0x00 control, 0x04/0x08
// station address, 0x0C status,
// 0x10 interrupt mask
// Multicast: group bit of the
// first destination byte
// No buffer: one byte per
// strobe, in wire order
module wake_pattern_detector
  import wake_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Avalon-MM slave
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Receive byte stream from MAC datapath
  input wire logic rx_sof_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_eof_i,
  // Power state from power management
  input wire wake_pkg::power_state_e power_state_i,
  // Normal reception gate and notifications
  output logic rx_normal_en_o,
  output logic wake_frame_det_en_o,
  output logic irq_o,
  output logic power_event_out_o
);

  import wake_pkg::*;

  // ****************************************
  // Reset release
  // ****************************************
  // Pin may fall at any time;
  // it rises in step with clock
  logic rst_meta_q; // First stage, read only by second
  logic rst_n_q;    // Released reset for the design

  // Two stages keep a late rise
  // of one flop out of the logic
  // Cost: two idle edges after
  // each release

  // Two-stage release of the asynchronous reset
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // Plain flops; reset clears all,
  // station address too, so
  // software writes it again

  logic wake_pattern_enable_q; // Detection mode request
  logic irq_notify_q;          // Route match to interrupt
  logic pme_notify_q;          // Route match to power event
  logic wuf_enable_q;          // Wake-up frame enable
  logic wake_pattern_received_q; // Sticky match flag
  logic [47:0] station_q;      // Station address
  logic [1:0] sts_q;           // Sticky events: match, mode change
  logic [1:0] mask_q;          // Interrupt mask
  logic ack_q;                 // One-cycle answer phase
  logic light_sleep;           // In light_sleep_state
  logic active;                // Detector running
  logic active_q;              // Previous active, for mode edge
  logic rd_ctrl;               // Read strobe on control register
  logic rd_sts;                // Read strobe on status register
  logic wr_go;                 // Write takes effect
  logic [31:0] rd_mux;         // Read data select

  // Bundle to the scanner; all but
  // the match pulse driven here
  // Match: one cycle, after the
  // last byte of the last copy
  wake_scan_if sif();

  // Power state: a level on this
  // clock; other states stop
  // detection
  // Light sleep needs no write:
  // the host may be asleep then

  // Light sleep turns detection on by itself
  assign light_sleep = (power_state_i == PWR_LIGHT);
  // Full power needs the enable bit; light sleep needs nothing
  assign active = ((power_state_i == PWR_FULL) && wake_pattern_enable_q) || light_sleep;
  // Normal reception off while detecting, back on when cleared
  assign rx_normal_en_o = !active;
  // Wake-up frame detection also forced in light sleep
  assign wake_frame_det_en_o = wuf_enable_q || light_sleep;

  // ****************************************
  // Avalon-MM handshake
  // ****************************************
  // Fixed latency keeps it simple
  // Cost: two cycles per access,
  // fine for rare accesses
  // Back-to-back requests each
  // get one wait cycle

  // Every access waits one cycle, then completes
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;
  assign wr_go = avs_write_i && ack_q;
  assign rd_ctrl = avs_read_i && ack_q && (avs_address_i == 5'(ADDR_CTRL));
  assign rd_sts = avs_read_i && ack_q && (avs_address_i == 5'(ADDR_IRQ_STS));

  // Drops after each completion,
  // so a held request waits again
  // Answer phase toggles so back-to-back requests each get a wait
  always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read_i || avs_write_i) && !ack_q;
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  // Lane 0 only; lane 0 off
  // changes nothing
  // Received bit: read only
  // Bit 4 only feeds the wake
  // frame output

  // Control register writes
  always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wake_pattern_enable_q <= CTRL_RESET[CTRL_EN_BIT];
      irq_notify_q <= CTRL_RESET[CTRL_IRQ_EN_BIT];
      pme_notify_q <= CTRL_RESET[CTRL_PME_EN_BIT];
      wuf_enable_q <= CTRL_RESET[CTRL_WUF_EN_BIT];
    end else if (wr_go && avs_address_i == 5'(ADDR_CTRL) && avs_byteenable_i[0]) begin
      wake_pattern_enable_q <= avs_writedata_i[CTRL_EN_BIT];
      irq_notify_q <= avs_writedata_i[CTRL_IRQ_EN_BIT];
      pme_notify_q <= avs_writedata_i[CTRL_PME_EN_BIT];
      wuf_enable_q <= avs_writedata_i[CTRL_WUF_EN_BIT];
    end
  end

  // ****************************************
  // Station address
  // ****************************************
  // Byte 0 first on the wire,
  // in bits 7:0 of the low word
  // Upper high-word lanes unused
  // Half-written address may match
  // a mixed value: write both
  // words before enabling

  // Station address, byte lanes honoured
  always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      station_q <= MAC_RESET;
    end else if (wr_go) begin
      for (int i = 0; i < 4; i++) begin
        if (avs_address_i == 5'(ADDR_MAC_LO) && avs_byteenable_i[i]) begin
          station_q[i*8 +: 8] <= avs_writedata_i[i*8 +: 8];
        end
        if (avs_address_i == 5'(ADDR_MAC_HI) && avs_byteenable_i[i] && i < 2) begin
          station_q[32 + i*8 +: 8] <= avs_writedata_i[i*8 +: 8];
        end
      end
    end
  end

  // ****************************************
  // Interrupt mask and status
  // ****************************************
  // Mask bit 0 passes a match,
  // bit 1 a mode change
  // Mask is kept as written

  // Mask register
  always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mask_q <= 2'b00;
    end else if (wr_go && avs_address_i == ADDR_MASK && avs_byteenable_i[0]) begin
      mask_q <= avs_writedata_i[1:0];
    end
  end

  // Read data is latched a cycle
  // before the clear; a match in
  // between must not be lost, so
  // only a shown bit is cleared
  // Received flag: set on match, read clears, set wins
  always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wake_pattern_received_q <= 1'b0;
    end else if (sif.match) begin
      wake_pattern_received_q <= 1'b1;
    end else if (rd_ctrl && avs_readdata_o[CTRL_RCVD_BIT]) begin
      wake_pattern_received_q <= 1'b0;
    end
  end

  // Clear rule as for the flag
  // Mode change: every toggle, by
  // software or by power state
  // Sticky events: bit0 match (if routed to irq), bit1 mode change; read clears
  always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sts_q <= 2'b00;
      active_q <= 1'b0;
    end else begin
      active_q <= active;
      for (int i = 0; i < 2; i++) begin
        if (rd_sts && avs_readdata_o[i]) begin
          sts_q[i] <= 1'b0;
        end
      end
      if (sif.match && irq_notify_q) begin
        sts_q[0] <= 1'b1;
      end
      if (active != active_q) begin
        sts_q[1] <= 1'b1;
      end
    end
  end

  // Event out: a level held until
  // a control read or a control
  // write that clears bit 3; the match term
  // wakes the host a cycle sooner
  // Both routes may be on

  // Power event follows the flag while routed there
  always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      power_event_out_o <= 1'b0;
    end else begin
      power_event_out_o <= pme_notify_q && (wake_pattern_received_q || sif.match);
    end
  end

  // Level from flops, high while
  // an unmasked event stands
  assign irq_o = |(sts_q & mask_q);

  // ****************************************
  // Read data
  // ****************************************
  // Unmapped offsets read zero
  // No side effects here; the
  // clearing reads act above
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address_i)
      5'(ADDR_CTRL): begin
        rd_mux[CTRL_EN_BIT] = wake_pattern_enable_q;
        rd_mux[CTRL_RCVD_BIT] = wake_pattern_received_q;
        rd_mux[CTRL_IRQ_EN_BIT] = irq_notify_q;
        rd_mux[CTRL_PME_EN_BIT] = pme_notify_q;
        rd_mux[CTRL_WUF_EN_BIT] = wuf_enable_q;
      end
      5'(ADDR_MAC_LO): rd_mux = station_q[31:0];
      5'(ADDR_MAC_HI): rd_mux = {16'h0000, station_q[47:32]};
      5'(ADDR_IRQ_STS): rd_mux = {30'h0000_0000, sts_q};
      ADDR_MASK: rd_mux = {30'h0000_0000, mask_q};
      default: rd_mux = 32'h0000_0000; // Unmapped reads zero
    endcase
  end

  // Latched in the waiting cycle,
  // it stands while wait is low
  // and the master takes it
  // Read data registered at the edge that ends the wait cycle, one edge before completion
  always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && !ack_q) begin
      avs_readdata_o <= rd_mux;
    end
  end

  // ****************************************
  // Scanner hookup: start and byte strobes reach it only in detection mode
  // ****************************************
  // Stream inputs share this
  // clock, so no sync stages
  // Start and strobes are gated;
  // end of frame always passes,
  // it only idles the scanner
  // Station address fed live
  assign sif.active = active;
  assign sif.station = station_q;
  assign sif.sof = rx_sof_i && active;
  assign sif.byte_vld = rx_valid_i && active;
  assign sif.byte_dat = rx_data_i;
  assign sif.eof = rx_eof_i;

  // Scanner on released reset
  wake_scanner u_scanner (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n_q),
    .sif(sif)
  );

endmodule // wake_pattern_detector

`default_nettype wire

/* File: wake_pkg.sv */
package wake_pkg;

  // ****************************************
  // Register map (byte addresses, word aligned)
  // ****************************************
  localparam logic [3:0] ADDR_CTRL = 4'h0;      // wake_control_status
  localparam logic [3:0] ADDR_MAC_LO = 4'h4;    // Station address bytes 0..3
  localparam logic [3:0] ADDR_MAC_HI = 4'h8;    // Station address bytes 4..5
  localparam logic [3:0] ADDR_IRQ_STS = 4'hC;   // Sticky event status
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h0;  // Unused alias guard
  localparam logic [4:0] ADDR_MASK = 5'h10;     // Interrupt mask

  // ****************************************
  // Control field positions
  // ****************************************
  localparam int CTRL_EN_BIT = 0;       // wake_pattern_enable
  localparam int CTRL_RCVD_BIT = 1;     // wake_pattern_received (read clears)
  localparam int CTRL_IRQ_EN_BIT = 2;   // Notify via interrupt
  localparam int CTRL_PME_EN_BIT = 3;   // Notify via power_event_out
  localparam int CTRL_WUF_EN_BIT = 4;   // Wake-up frame detect enable (shown)

  // ****************************************
  // Reset values and pattern constants
  // ****************************************
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic [47:0] MAC_RESET = 48'h0000_0000_0000;
  localparam logic [7:0] SYNC_BYTE = 8'hFF;
  localparam logic [2:0] SYNC_LEN = 3'h6;      // Six 0xFF bytes
  localparam logic [4:0] REP_COUNT = 5'h10;    // Sixteen address copies
  localparam logic [3:0] HDR_LEN = 4'hC;       // Destination plus source bytes
  localparam logic [2:0] ADDR_LEN = 3'h6;      // Bytes in one address
  localparam logic [47:0] BCAST_ADDR = 48'hFFFF_FFFF_FFFF;

  // ****************************************
  // Scanner states
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HDR = 2'b01,
    ST_SYNC = 2'b11,
    ST_REP = 2'b10
  } scan_state_e;

  typedef enum logic [1:0] {
    PWR_FULL = 2'b00,   // full_power_state
    PWR_LIGHT = 2'b01,  // light_sleep_state
    PWR_OTHER = 2'b11
  } power_state_e;

endpackage

/* File: wake_scan_if.sv */
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// Scanner link between register side and pattern scanner
// ****************************************
interface wake_scan_if;
  logic active;        // Detection mode on
  logic [47:0] station;// Station address, byte 0 in bits 7:0
  logic sof;           // Frame start pulse
  logic byte_vld;      // Received byte strobe
  logic [7:0] byte_dat;// Received byte
  logic eof;           // Frame end pulse
  logic match;         // One-cycle match pulse

  modport ctrl (output active, station, sof, byte_vld, byte_dat, eof, input match);
  modport scan (input active, station, sof, byte_vld, byte_dat, eof, output match);
endinterface

`default_nettype wire

/* File: wake_scanner.sv */
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// Wake pattern byte scanner
// ****************************************
module wake_scanner
  import wake_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  wake_scan_if.scan sif
);

  scan_state_e state_q;      // Scanner state
  logic [3:0] hdr_cnt_q;     // Header byte index
  logic [2:0] sync_cnt_q;    // Consecutive 0xFF count
  logic [2:0] byte_idx_q;    // Position within address copy
  logic [4:0] rep_cnt_q;     // Whole copies seen
  logic [47:0] dst_q;        // Captured destination
  logic addr_ok_q;           // Frame addressed to us
  logic [7:0] exp_byte;      // Expected address byte
  logic dst_ok;              // Destination accepted

  // Wire order: byte 0 of the station address goes first
  assign exp_byte = sif.station[byte_idx_q*8 +: 8];

  // Own, broadcast or any multicast (group bit in first byte)
  assign dst_ok = (dst_q == sif.station) || (dst_q == BCAST_ADDR) || dst_q[0];

  // Main scan sequence
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      hdr_cnt_q <= 4'h0;
      sync_cnt_q <= 3'h0;
      byte_idx_q <= 3'h0;
      rep_cnt_q <= 5'h00;
      dst_q <= MAC_RESET;
      addr_ok_q <= 1'b0;
      sif.match <= 1'b0;
    end else begin
      sif.match <= 1'b0;
      if (!sif.active) begin
        // Leaving detection mode drops any partial match
        state_q <= ST_IDLE;
      end else if (sif.sof) begin
        // Fresh frame wipes all progress
        state_q <= ST_HDR;
        hdr_cnt_q <= 4'h0;
        sync_cnt_q <= 3'h0;
        byte_idx_q <= 3'h0;
        rep_cnt_q <= 5'h00;
        addr_ok_q <= 1'b0;
      end else if (sif.eof) begin
        state_q <= ST_IDLE;
      end else if (sif.byte_vld) begin
        case (state_q)
          ST_HDR: begin
            if (hdr_cnt_q < 4'(ADDR_LEN)) begin
              dst_q[hdr_cnt_q[2:0]*8 +: 8] <= sif.byte_dat;
            end
            if (hdr_cnt_q == 4'(ADDR_LEN)) begin
              addr_ok_q <= dst_ok;
            end
            hdr_cnt_q <= hdr_cnt_q + 4'h1;
            // Search begins only past both address fields
            if (hdr_cnt_q == HDR_LEN - 4'h1) begin
              state_q <= ST_SYNC;
            end
          end
          ST_SYNC: begin
            if (!addr_ok_q) begin
              // Foreign unicast: ignored for the rest of the frame
              state_q <= ST_SYNC;
            end else if (sif.byte_dat == SYNC_BYTE) begin
              // Sync run may start anywhere after header
              if (sync_cnt_q != SYNC_LEN) begin
                sync_cnt_q <= sync_cnt_q + 3'h1;
              end
            end else if (sync_cnt_q == SYNC_LEN && sif.byte_dat == exp_byte) begin
              // Copies accepted only right after a sync run
              state_q <= ST_REP;
              byte_idx_q <= 3'h1;
              rep_cnt_q <= 5'h00;
              sync_cnt_q <= 3'h0;
            end else begin
              sync_cnt_q <= 3'h0;
            end
          end
          ST_REP: begin
            if (sif.byte_dat == exp_byte) begin
              if (byte_idx_q == ADDR_LEN - 3'h1) begin
                byte_idx_q <= 3'h0;
                rep_cnt_q <= rep_cnt_q + 5'h01;
                // Sixteen unbroken copies declare a match
                if (rep_cnt_q == REP_COUNT - 5'h01) begin
                  sif.match <= 1'b1;
                  state_q <= ST_SYNC;
                  rep_cnt_q <= 5'h00;
                end
              end else begin
                byte_idx_q <= byte_idx_q + 3'h1;
              end
            end else begin
              // Break: drop progress, rescan; an 0xFF may seed a new run
              state_q <= ST_SYNC;
              byte_idx_q <= 3'h0;
              rep_cnt_q <= 5'h00;
              sync_cnt_q <= (sif.byte_dat == SYNC_BYTE) ? 3'h1 : 3'h0;
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule // wake_scanner

`default_nettype wire

/* File: wake_pattern_detector_checker.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Port checker for the wake detector
// ****************************************
module wake_pattern_detector_checker
  import wake_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic avs_waitrequest_o,
  input wire logic rx_valid_i,
  input wire wake_pkg::power_state_e power_state_i,
  input wire logic rx_normal_en_o,
  input wire logic wake_frame_det_en_o,
  input wire logic irq_o,
  input wire logic power_event_out_o
);
  default clocking dcb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  logic wdone; // Write completes here
  logic rdone; // Read completes here
  logic ctl_w; // Control write completes here
  logic [5:0] vh_q; // Recent byte strobes
  logic [5:0] wh_q; // Recent completed writes
  assign wdone = avs_write_i && !avs_waitrequest_o;
  assign rdone = avs_read_i && !avs_waitrequest_o;
  assign ctl_w = wdone && avs_address_i == 5'h00;
  // Flags rise a few cycles after a byte or a write, irq also after a power state change if mask bit 1 is set; bytes and writes kept in view
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      vh_q <= 6'h00;
      wh_q <= 6'h00;
    end else begin
      vh_q <= {vh_q[4:0], rx_valid_i};
      wh_q <= {wh_q[4:0], wdone};
    end
  end
  property p_gate_on; ctl_w && avs_writedata_i[0] |=> !rx_normal_en_o; endproperty
  a_gate_on: assert property (p_gate_on) else $error("normal path still open");
  property p_gate_off;
    ctl_w && !avs_writedata_i[0] && power_state_i == PWR_FULL |=> rx_normal_en_o;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("normal path not back");
  property p_light; power_state_i == PWR_LIGHT |-> !rx_normal_en_o && wake_frame_det_en_o; endproperty
  a_light: assert property (p_light) else $error("light sleep not detecting");
  property p_pme_cause; $rose(power_event_out_o) |-> (|vh_q) || (|wh_q); endproperty
  a_pme_cause: assert property (p_pme_cause) else $error("event out without cause");
  property p_irq_cause; $rose(irq_o) |-> (|vh_q) || (|wh_q); endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without cause");
  property p_pme_hold;
    power_event_out_o && !rdone && !$past(rdone) && !wdone && !$past(wdone) |=> power_event_out_o;
  endproperty
  a_pme_hold: assert property (p_pme_hold) else $error("event out dropped");
  property p_irq_clr;
    rdone && avs_address_i == 5'h0C && !(|vh_q) && !rx_valid_i |=> !irq_o;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("status read kept interrupt");
  property p_wait_one; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("bus wait too long");
  c_match: cover property ($rose(power_event_out_o));
  c_irq: cover property ($rose(irq_o));
  c_light: cover property (power_state_i == PWR_LIGHT && rx_valid_i);
endmodule // wake_pattern_detector_checker

bind wake_pattern_detector wake_pattern_detector_checker u_wake_pattern_detector_checker (
  .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_waitrequest_o(avs_waitrequest_o), .rx_valid_i(rx_valid_i),
  .power_state_i(power_state_i), .rx_normal_en_o(rx_normal_en_o),
  .wake_frame_det_en_o(wake_frame_det_en_o), .irq_o(irq_o),
  .power_event_out_o(power_event_out_o));
`default_nettype wire

/* File: rx_stream_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Receive datapath stand-in
// ****************************************
module rx_stream_model (
  input wire logic clk_i,
  output logic rx_sof_o,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic rx_eof_o
);
  initial begin
    rx_sof_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
    rx_eof_o = 1'b0;
  end
  // One frame; gap adds idle cycles between bytes for a slow source
  task automatic send(input logic [7:0] q[$], input int gap);
    @(posedge clk_i);
    rx_sof_o <= 1'b1;
    @(posedge clk_i);
    rx_sof_o <= 1'b0;
    foreach (q[i]) begin
      rx_valid_o <= 1'b1;
      rx_data_o <= q[i];
      @(posedge clk_i);
      if (gap > 0) begin
        // Idle data inverted so a stale byte is never taken twice
        rx_valid_o <= 1'b0;
        rx_data_o <= ~q[i];
        repeat (gap) @(posedge clk_i);
      end
    end
    rx_valid_o <= 1'b0;
    rx_data_o <= ~rx_data_o;
    rx_eof_o <= 1'b1;
    @(posedge clk_i);
    rx_eof_o <= 1'b0;
  endtask
endmodule // rx_stream_model
`default_nettype wire

/* File: tb_wake_pattern_detector.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Wake detector bench
// ****************************************
module tb_wake_pattern_detector;
  import wake_pkg::*;
  localparam logic [47:0] ST = 48'hF5E4D3C2B1A0; // Station address
  localparam logic [47:0] SA = 48'h0A0908070605; // Sender address
  localparam logic [63:0] GOOD = 64'h0650_0000_0000_0000; // Six sync, sixteen copies
  logic clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0; // Bench drives
  logic sof, vld, eof, wq, rxn, det, irq, power_event_out; // Stream and flags
  logic [4:0] adr = 5'h00;
  logic [31:0] wd = 32'h0, rdat, rdv, cfg;
  logic [7:0] dat;
  logic [7:0] fq[$]; // Frame being built
  power_state_e pwr = PWR_FULL;
  int error_cnt = 0, n_compared = 0;
  always #50 clk = ~clk;
  wake_pattern_detector u_wake_pattern_detector (.sys_clk_i(clk), .rstn_i(rstn),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(4'hF), .avs_readdata_o(rdat), .avs_waitrequest_o(wq),
    .rx_sof_i(sof), .rx_valid_i(vld), .rx_data_i(dat), .rx_eof_i(eof),
    .power_state_i(pwr), .rx_normal_en_o(rxn), .wake_frame_det_en_o(det),
    .irq_o(irq), .power_event_out_o(power_event_out));
  rx_stream_model u_rx_stream_model (.clk_i(clk), .rx_sof_o(sof), .rx_valid_o(vld),
    .rx_data_o(dat), .rx_eof_o(eof));
  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One access; held until wait is seen low, bounded so a hang ends the run
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wq !== 1'b0 && n < 20);
    rdv = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wq !== 1'b0) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask
  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdv, e);
  endtask
  // ****************************************
  // Frame building and checking
  // ****************************************
  // Segment byte: kind in top two bits (sync, copy, filler, reversed copy), count below
  task automatic bld(input logic [47:0] d, input logic [47:0] s, input logic [63:0] sp);
    for (int i = 0; i < 12; i++) begin
      fq.push_back(i < 6 ? d[8*i+:8] : s[8*(i-6)+:8]);
    end
    for (int g = 7; g >= 0; g--) begin
      for (int i = 0; i < sp[8*g+:6] * (sp[8*g+6] ? 6 : 1); i++) begin
        case (sp[8*g+6+:2])
          2'h0: fq.push_back(SYNC_BYTE);
          2'h1: fq.push_back(ST[8*(i%6)+:8]);
          2'h2: fq.push_back(8'h00);
          default: fq.push_back(ST[8*(5-i%6)+:8]);
        endcase
      end
    end
  endtask
  // Flags, received bit (read clears it) and status after one frame
  task automatic run(input logic [47:0] d, input logic [47:0] s, input logic [63:0] sp,
                     input logic e, input logic ei, input int gap);
    bld(d, s, sp);
    u_rx_stream_model.send(fq, gap);
    fq.delete();
    repeat (6) @(posedge clk);
    chk({30'h0, power_event_out, irq}, {30'h0, e, ei});
    rchk(5'h00, cfg | {30'h0, e, 1'b0});
    bus(1'b0, 5'h0C, 32'h0);
    chk(rdv & 32'h1, {31'h0, e});
    @(posedge clk);
    chk({30'h0, power_event_out, irq}, 32'h0);
  endtask
  initial begin
    #5000000;
    error_cnt++;
    tally_and_finish();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    chk({28'h0, rxn, det, irq, power_event_out}, 32'h8);
    rchk(5'h00, {27'h0, CTRL_RESET});
    rchk(5'h04, MAC_RESET[31:0]);
    rchk(5'h10, 32'h0);
    bus(1'b1, 5'h14, 32'hFFFFFFFF);
    rchk(5'h14, 32'h0);
    bus(1'b1, 5'h04, ST[31:0]);
    bus(1'b1, 5'h08, {16'h0, ST[47:32]});
    rchk(5'h08, {16'h0, ST[47:32]});
    cfg = 32'hD;
    bus(1'b1, 5'h00, cfg);
    @(posedge clk);
    chk({31'h0, rxn}, 32'h0);
    bus(1'b0, 5'h0C, 32'h0);
    run(ST, SA, GOOD, 1'b1, 1'b0, 0); // Mask clear keeps irq low
    bus(1'b1, 5'h10, 32'h1);
    run(BCAST_ADDR, SA, GOOD, 1'b1, 1'b1, 1); // Slow source
    run(48'h665544332201, SA, GOOD, 1'b1, 1'b1, 0);
    run(48'h665544332202, SA, GOOD, 1'b0, 1'b0, 0);
    run(ST, SA, 64'h0550 << 48, 1'b0, 1'b0, 0);
    run(ST, BCAST_ADDR, 64'h50 << 56, 1'b0, 1'b0, 0);
    run(ST, SA, 64'h064F << 48, 1'b0, 1'b0, 0);
    run(ST, SA, 64'h0750 << 48, 1'b1, 1'b1, 0);
    run(ST, SA, 64'h0648_8106_50 << 24, 1'b1, 1'b1, 0);
    run(ST, SA, 64'h0648_8150 << 32, 1'b0, 1'b0, 0);
    run(ST, SA, 64'h06D0 << 48, 1'b0, 1'b0, 0);
    bld(ST, SA, 64'h0648 << 48);
    u_rx_stream_model.send(fq, 0);
    fq.delete();
    run(ST, SA, 64'h48 << 56, 1'b0, 1'b0, 0);
    cfg = 32'h1C;
    bus(1'b1, 5'h00, cfg);
    @(posedge clk);
    chk({30'h0, rxn, det}, 32'h3);
    run(ST, SA, GOOD, 1'b0, 1'b0, 0);
    pwr <= PWR_LIGHT;
    @(posedge clk);
    chk({30'h0, rxn, det}, 32'h1);
    rchk(5'h0C, 32'h2);
    run(ST, SA, GOOD, 1'b1, 1'b1, 0);
    tally_and_finish();
  end
endmodule // tb_wake_pattern_detector
`default_nettype wire
